// ==== hdl/gpx_port.sv ====
// GPIO port with alternate functions and external interrupt requests
`default_nettype none

module gpx_port
  import gpx_pkg::*;
#(
  parameter int PIN_COUNT = 8,
  parameter logic [7:0] IRQ_PIN_MASK = 8'hFF,
  parameter logic [7:0] IRQ_PULLUP_MASK = 8'hFF,
  parameter logic [7:0] GROUP_A_MASK = 8'h0F,
  parameter logic [7:0] GROUP_B_MASK = 8'hF0
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Avalon-MM register slave
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Pads
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe_out,
  output logic [PIN_COUNT-1:0] pull_up_en_out,
  // Peripheral alternate functions
  input wire logic [PIN_COUNT-1:0] alt_out_en_in,
  input wire logic [PIN_COUNT-1:0] alt_out_in,
  input wire logic [PIN_COUNT-1:0] alt_open_drain_in,
  output logic [PIN_COUNT-1:0] alt_in_out,
  // External interrupt requests and vector fetch acknowledges
  input wire logic [GRP_COUNT-1:0] irq_ack_in,
  output logic [GRP_COUNT-1:0] irq_req_out
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter check

  generate
    if (PIN_COUNT < 1 || PIN_COUNT > REG_W)
    begin : g_bad_width
      $error("gpx_port: PIN_COUNT must be 1 to 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  gpx_bus_state_t bus_state;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic byte0_en;
  logic [PIN_COUNT-1:0] port_data;
  logic [PIN_COUNT-1:0] port_direction;
  logic [PIN_COUNT-1:0] port_option;
  logic [1:0] group_a_sense_code;
  logic [1:0] group_b_sense_code;
  logic port_a_polarity_invert;
  logic port_b_polarity_invert;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev;
  logic [PIN_COUNT-1:0] irq_enable;
  logic [PIN_COUNT-1:0] read_view;
  logic [PIN_COUNT-1:0] next_pad_out;
  logic [PIN_COUNT-1:0] next_pad_oe;
  logic [PIN_COUNT-1:0] next_pull_up;
  logic [REG_W-1:0] next_readdata;
  logic [REG_W-1:0] sense_cfg_view;
  logic [GRP_COUNT-1:0] group_event;
  logic [GRP_COUNT-1:0] cfg_change;
  logic [REG_W-1:0] wdata;
  logic [PIN_COUNT-1:0] grp_a_pins;
  logic [PIN_COUNT-1:0] grp_b_pins;
  default clocking ast_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  assign wdata = avs_writedata_in[REG_W-1:0];
  assign grp_a_pins = GROUP_A_MASK[PIN_COUNT-1:0];
  assign grp_b_pins = GROUP_B_MASK[PIN_COUNT-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake: one wait state for every access

  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req && (bus_state == GPX_BUS_IDLE);
  assign bus_take = bus_req && (bus_state == GPX_BUS_ACK);
  assign byte0_en = avs_byteenable_in[0];
  assign wr_take = bus_take && avs_write_in && byte0_en;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      bus_state <= GPX_BUS_IDLE;
    end
    else
    begin
      case (bus_state)
        GPX_BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_state <= GPX_BUS_ACK;
          end
        end
        GPX_BUS_ACK: bus_state <= GPX_BUS_IDLE;
        default: bus_state <= GPX_BUS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port registers

  // Latch always takes the write; input pins simply ignore it
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      port_data <= RST_PORT_DATA[PIN_COUNT-1:0];
      port_direction <= RST_PORT_DIRECTION[PIN_COUNT-1:0];
      port_option <= RST_PORT_OPTION[PIN_COUNT-1:0];
    end
    else if (wr_take)
    begin
      case (avs_address_in)
        OFF_PORT_DATA: port_data <= wdata[PIN_COUNT-1:0];
        OFF_PORT_DIRECTION: port_direction <= wdata[PIN_COUNT-1:0];
        OFF_PORT_OPTION: port_option <= wdata[PIN_COUNT-1:0];
        default: port_data <= port_data;
      endcase
    end
  end

  // Sense configuration
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      group_b_sense_code <= RST_SENSE_CFG[SNS_B_HI:SNS_B_LO];
      port_b_polarity_invert <= RST_SENSE_CFG[SNS_B_INV];
      group_a_sense_code <= RST_SENSE_CFG[SNS_A_HI:SNS_A_LO];
      port_a_polarity_invert <= RST_SENSE_CFG[SNS_A_INV];
    end
    else if (wr_take && avs_address_in == OFF_SENSE_CFG)
    begin
      group_b_sense_code <= wdata[SNS_B_HI:SNS_B_LO];
      port_b_polarity_invert <= wdata[SNS_B_INV];
      group_a_sense_code <= wdata[SNS_A_HI:SNS_A_LO];
      port_a_polarity_invert <= wdata[SNS_A_INV];
    end
  end

  always_comb
  begin
    sense_cfg_view = '0;
    sense_cfg_view[SNS_B_HI:SNS_B_LO] = group_b_sense_code;
    sense_cfg_view[SNS_B_INV] = port_b_polarity_invert;
    sense_cfg_view[SNS_A_HI:SNS_A_LO] = group_a_sense_code;
    sense_cfg_view[SNS_A_INV] = port_a_polarity_invert;
  end

  // A write that alters a group's sense fields cancels its request
  always_comb
  begin
    cfg_change = '0;
    if (wr_take && avs_address_in == OFF_SENSE_CFG)
    begin
      cfg_change[GRP_A] = (wdata[SNS_A_HI:SNS_A_INV]
        != sense_cfg_view[SNS_A_HI:SNS_A_INV]);
      cfg_change[GRP_B] = (wdata[SNS_B_HI:SNS_B_INV]
        != sense_cfg_view[SNS_B_HI:SNS_B_INV]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, latched in the wait cycle so it stands at acceptance

  always_comb
  begin
    next_readdata = '0;
    case (avs_address_in)
      OFF_PORT_DATA: next_readdata[PIN_COUNT-1:0] = read_view;
      OFF_PORT_DIRECTION: next_readdata[PIN_COUNT-1:0] = port_direction;
      OFF_PORT_OPTION: next_readdata[PIN_COUNT-1:0] = port_option;
      OFF_SENSE_CFG: next_readdata = sense_cfg_view & SENSE_CFG_MASK;
      default: next_readdata = '0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      avs_readdata_out <= '0;
    end
    else if (avs_read_in && bus_state == GPX_BUS_IDLE)
    begin
      avs_readdata_out <= {{(DATA_W-REG_W){1'b0}}, next_readdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin input path

  gpx_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      pin_prev <= '0;
    end
    else
    begin
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin configuration decode

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      logic is_out;
      logic alt_drv;
      assign is_out = port_direction[gi];
      assign alt_drv = alt_out_en_in[gi];
      // Peripheral output forces drive in its own style
      assign next_pad_out[gi] = alt_drv ? alt_out_in[gi]
        : (is_out && port_option[gi] && port_data[gi]);
      assign next_pad_oe[gi] = alt_drv
        ? (!alt_open_drain_in[gi] || !alt_out_in[gi])
        : (is_out && (port_option[gi] || !port_data[gi]));
      // Interrupt pins without pull-up float on option set
      assign next_pull_up[gi] = !alt_drv && !is_out && port_option[gi]
        && (!IRQ_PIN_MASK[gi] || IRQ_PULLUP_MASK[gi]);
      // Alternate output must not feed the interrupt logic
      assign irq_enable[gi] = IRQ_PIN_MASK[gi] && !alt_drv
        && !is_out && port_option[gi];
      assign read_view[gi] = is_out ? port_data[gi]
        : (alt_drv ? alt_out_in[gi] : pin_sync[gi]);
    end
  endgenerate

  // Data outputs leave from flip-flops
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      pad_out <= '0;
      pad_oe_out <= '0;
      pull_up_en_out <= '0;
      alt_in_out <= '0;
    end
    else
    begin
      pad_out <= next_pad_out;
      pad_oe_out <= next_pad_oe;
      pull_up_en_out <= next_pull_up;
      alt_in_out <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External interrupt groups

  gpx_sense #(
    .WIDTH(PIN_COUNT)
  ) u_sense_a (
    .level_in(pin_sync),
    .prev_in(pin_prev),
    .enable_in(irq_enable & grp_a_pins),
    .code_in(group_a_sense_code),
    .invert_in(port_a_polarity_invert),
    .event_out(group_event[GRP_A])
  );

  gpx_sense #(
    .WIDTH(PIN_COUNT)
  ) u_sense_b (
    .level_in(pin_sync),
    .prev_in(pin_prev),
    .enable_in(irq_enable & grp_b_pins),
    .code_in(group_b_sense_code),
    .invert_in(port_b_polarity_invert),
    .event_out(group_event[GRP_B])
  );

  // Hidden request latch: discard beats event, event beats fetch
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      irq_req_out <= '0;
    end
    else
    begin
      for (int g = 0; g < GRP_COUNT; g++)
      begin
        if (cfg_change[g])
          irq_req_out[g] <= 1'b0;
        else if (group_event[g])
          irq_req_out[g] <= 1'b1;
        else if (irq_ack_in[g])
          irq_req_out[g] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_ONE_WAIT: assert property (bus_req && avs_waitrequest_out
    |=> !avs_waitrequest_out)
    else $error("access not accepted after one wait state");
  AST_PP_DRIVE: assert property (port_direction[0] && port_option[0]
    && !alt_out_en_in[0]
    |=> pad_oe_out[0] && pad_out[0] == $past(port_data[0]))
    else $error("push-pull pin not driving latch");
  AST_OD_RELEASE: assert property (port_direction[0] && !port_option[0]
    && !alt_out_en_in[0]
    |=> pad_oe_out[0] == !$past(port_data[0]) && !pad_out[0])
    else $error("open-drain pin drive wrong");
  AST_INPUT_QUIET: assert property (!port_direction[0]
    && !alt_out_en_in[0] |=> !pad_oe_out[0])
    else $error("input pin driven");
  AST_ALT_OVERRIDE: assert property (alt_out_en_in[0]
    && !alt_open_drain_in[0]
    |=> pad_oe_out[0] && pad_out[0] == $past(alt_out_in[0]))
    else $error("alternate output not driving pin");
  AST_PULLUP: assert property (!port_direction[0] && port_option[0]
    && !alt_out_en_in[0] && (!IRQ_PIN_MASK[0] || IRQ_PULLUP_MASK[0])
    |=> pull_up_en_out[0])
    else $error("pull-up not enabled");
  AST_EVENT_SETS: assert property (group_event[GRP_A]
    && !cfg_change[GRP_A] |=> irq_req_out[GRP_A] ##1 (irq_req_out[GRP_A]
    || $past(irq_ack_in[GRP_A]) || $past(cfg_change[GRP_A])))
    else $error("qualified event lost");
  AST_ACK_CLEARS: assert property (irq_ack_in[GRP_B]
    && !group_event[GRP_B] |=> !irq_req_out[GRP_B])
    else $error("vector fetch did not clear request");
  AST_CFG_DISCARD: assert property (cfg_change[GRP_A]
    |=> !irq_req_out[GRP_A])
    else $error("sense change did not discard request");
  AST_PIN_LATENCY: assert property ($stable(pad_in) [*3]
    |-> pin_sync == pad_in)
    else $error("synchronised level wrong after two stages");

endmodule // gpx_port

`default_nettype wire

// ==== hdl/gpx_pkg.sv ====
// Constants, field layout and codes shared by the GPIO port design
`default_nettype none

package gpx_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on a 32-bit Avalon-MM slave
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIRECTION = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_PORT_OPTION = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_SENSE_CFG = 5'h0C;

  // Reset values
  localparam logic [REG_W-1:0] RST_PORT_DATA = 8'h00;
  localparam logic [REG_W-1:0] RST_PORT_DIRECTION = 8'h00;
  localparam logic [REG_W-1:0] RST_PORT_OPTION = 8'h00;
  localparam logic [REG_W-1:0] RST_SENSE_CFG = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Sense configuration fields
  localparam int SNS_B_HI = 7;
  localparam int SNS_B_LO = 6;
  localparam int SNS_B_INV = 5;
  localparam int SNS_A_HI = 4;
  localparam int SNS_A_LO = 3;
  localparam int SNS_A_INV = 2;
  localparam logic [REG_W-1:0] SENSE_CFG_MASK = 8'hFC;

  // Sense codes
  localparam logic [1:0] SENSE_LOW_FALL = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // Interrupt groups: index 0 is group A, index 1 is group B
  localparam int GRP_COUNT = 2;
  localparam int GRP_A = 0;
  localparam int GRP_B = 1;

  // Bus handshake states
  typedef enum logic [1:0] {
    GPX_BUS_IDLE = 2'b01,
    GPX_BUS_ACK = 2'b10
  } gpx_bus_state_t;

endpackage : gpx_pkg

`default_nettype wire

// ==== hdl/gpx_sync.sv ====
// Two-stage synchroniser for the pin levels
`default_nettype none

module gpx_sync
  import gpx_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Asynchronous levels in, synchronous levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      stage_one <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // gpx_sync

`default_nettype wire

// ==== hdl/gpx_sense.sv ====
// Sensitivity qualifier for one external interrupt group
`default_nettype none

module gpx_sense
  import gpx_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Synchronised level now and one cycle earlier
  input wire logic [WIDTH-1:0] level_in,
  input wire logic [WIDTH-1:0] prev_in,
  // Pins of this group enabled as interrupt sources
  input wire logic [WIDTH-1:0] enable_in,
  // Group sensitivity
  input wire logic [1:0] code_in,
  input wire logic invert_in,
  // Qualified and ORed event
  output logic event_out
);

  logic [WIDTH-1:0] now_lvl;
  logic [WIDTH-1:0] old_lvl;
  logic [WIDTH-1:0] hit;

  // Inversion swaps rising with falling and low with high
  assign now_lvl = invert_in ? ~level_in : level_in;
  assign old_lvl = invert_in ? ~prev_in : prev_in;

  always_comb
  begin
    case (code_in)
      SENSE_LOW_FALL: hit = ~now_lvl;
      SENSE_RISE: hit = now_lvl & ~old_lvl;
      SENSE_FALL: hit = ~now_lvl & old_lvl;
      SENSE_BOTH: hit = now_lvl ^ old_lvl;
      default: hit = '0;
    endcase
  end

  // Each pin qualified first, then combined
  assign event_out = |(hit & enable_in);

endmodule // gpx_sense

`default_nettype wire

// ==== verification/gpx_pins_model.sv ====
// Far-side pin model: resolves each pad from port, outside driver, pull-up
`default_nettype none

module gpx_pins_model
(
  // Clock for the floating pattern
  input wire logic clk_in,
  // Port side of the pads
  input wire logic [7:0] pad_out_in,
  input wire logic [7:0] pad_oe_in,
  input wire logic [7:0] pull_up_en_in,
  // Outside driver
  input wire logic [7:0] ext_drv_in,
  input wire logic [7:0] ext_val_in,
  // Resolved level
  output logic [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] float_pat = 8'h55;

  // Undriven pins toggle, so a stale level never passes for a match
  always @(posedge clk_in)
    float_pat <= ~float_pat;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_oe_in[i])
        level_out[i] = pad_out_in[i];
      else if (ext_drv_in[i])
        level_out[i] = ext_val_in[i];
      else if (pull_up_en_in[i])
        level_out[i] = 1'b1;
      else
        level_out[i] = float_pat[i];
    end
  end
endmodule // gpx_pins_model

`default_nettype wire

// ==== verification/tb_gpio_port_with_ext_irq.sv ====
// Self-checking bench for the GPIO port
`default_nettype none

module tb_gpio_port_with_ext_irq;
  import gpx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] be = 4'hF;
  logic [DATA_W-1:0] rdata;
  logic waitreq;
  logic [7:0] pad_lvl, pad_out, pad_oe, pull_up, alt_in;
  logic [7:0] alt_en = 8'h00;
  logic [7:0] alt_val = 8'h00;
  logic [7:0] alt_od = 8'h00;
  logic [7:0] ext_drv = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  logic [1:0] ack = 2'h0;
  logic [1:0] irq;
  int n_mismatch = 0;
  int compares = 0;

  always #50 clk_in = ~clk_in;

  gpx_port gpx_port_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .pad_in(pad_lvl), .pad_out(pad_out), .pad_oe_out(pad_oe),
    .pull_up_en_out(pull_up), .alt_out_en_in(alt_en),
    .alt_out_in(alt_val), .alt_open_drain_in(alt_od),
    .alt_in_out(alt_in), .irq_ack_in(ack), .irq_req_out(irq)
  );

  gpx_pins_model gpx_pins_model_i (
    .clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .pull_up_en_in(pull_up), .ext_drv_in(ext_drv),
    .ext_val_in(ext_val), .level_out(pad_lvl)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One Avalon access; waitrequest is sampled at each rising edge and the
  // request is released only at the edge that sees it low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      end_sim();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic pulse_ack(input logic [1:0] g);
    @(posedge clk_in);
    ack <= g;
    @(posedge clk_in);
    ack <= 2'h0;
  endtask

  // Clear group A, move pin 0 to v, see whether the sense code fires
  task automatic irq_step(input logic v, input logic [1:0] c,
                          input logic inv);
    logic e;
    pulse_ack(2'h1);
    cyc(3);
    @(posedge clk_in);
    ext_val[0] <= v;
    cyc(5);
    e = (c == 2'h0) || (c == 2'h3) || (c == 2'h1 && (v ^ inv))
      || (c == 2'h2 && !(v ^ inv));
    check({31'h0, irq[0]}, {31'h0, e});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // Reset values, reserved bits, unmapped place, disabled byte lane
    rreg(OFF_PORT_DATA, RST_PORT_DATA);
    rreg(OFF_PORT_DIRECTION, RST_PORT_DIRECTION);
    rreg(OFF_PORT_OPTION, RST_PORT_OPTION);
    rreg(OFF_SENSE_CFG, RST_SENSE_CFG);
    wreg(5'h10, 8'hFF);
    rreg(5'h10, 8'h00);
    wreg(OFF_SENSE_CFG, 8'hFF);
    rreg(OFF_SENSE_CFG, SENSE_CFG_MASK);
    wreg(OFF_SENSE_CFG, 8'h00);
    be <= 4'hE;
    wreg(OFF_PORT_DIRECTION, 8'hFF);
    be <= 4'hF;
    rreg(OFF_PORT_DIRECTION, 8'h00);
    cyc(0);
    check({24'h0, pad_oe}, 32'h0);
    $display("Test registers done");
    // Input reads the pin, data write only loads the latch
    @(posedge clk_in);
    ext_val <= 8'hA5;
    cyc(4);
    rreg(OFF_PORT_DATA, 8'hA5);
    wreg(OFF_PORT_DATA, 8'h3C);
    rreg(OFF_PORT_DATA, 8'hA5);
    cyc(0);
    check({24'h0, pad_oe}, 32'h0);
    // Push-pull, then open-drain output
    @(posedge clk_in);
    ext_drv <= 8'h00;
    wreg(OFF_PORT_OPTION, 8'hFF);
    wreg(OFF_PORT_DIRECTION, 8'hFF);
    cyc(2);
    check({24'h0, pad_oe}, 32'hFF);
    check({24'h0, pad_out}, 32'h3C);
    check({24'h0, pull_up}, 32'h0);
    rreg(OFF_PORT_DATA, 8'h3C);
    wreg(OFF_PORT_OPTION, 8'h00);
    cyc(2);
    check({24'h0, pad_oe}, 32'hC3);
    check({24'h0, pad_out & pad_oe}, 32'h0);
    // Pull-up input, nothing else on the pins
    wreg(OFF_PORT_OPTION, 8'hFF);
    wreg(OFF_PORT_DIRECTION, 8'h00);
    cyc(4);
    check({24'h0, pull_up}, 32'hFF);
    rreg(OFF_PORT_DATA, 8'hFF);
    $display("Test pin modes done");
    // Peripheral output takes pin 0 over an input setting
    wreg(OFF_PORT_OPTION, 8'h00);
    ext_drv <= 8'hFE;
    ext_val <= 8'h00;
    alt_en <= 8'h01;
    alt_val <= 8'h01;
    cyc(4);
    check({24'h0, pad_oe & pad_out}, 32'h01);
    rreg(OFF_PORT_DATA, 8'h01);
    @(posedge clk_in);
    alt_od <= 8'h01;
    alt_val <= 8'h00;
    cyc(2);
    check({24'h0, pad_oe}, 32'h01);
    check({24'h0, pad_out}, 32'h00);
    @(posedge clk_in);
    alt_val <= 8'h01;
    cyc(2);
    check({24'h0, pad_oe}, 32'h00);
    // Peripheral input still readable as data
    @(posedge clk_in);
    alt_en <= 8'h00;
    ext_drv <= 8'hFF;
    ext_val <= 8'h5A;
    cyc(5);
    check({24'h0, alt_in}, 32'h5A);
    rreg(OFF_PORT_DATA, 8'h5A);
    $display("Test alternates done");
    // Every sense code and polarity on pin 0
    ext_val <= 8'h00;
    wreg(OFF_PORT_OPTION, 8'h51);
    for (int c = 0; c < 4; c++)
    begin
      for (int i = 0; i < 2; i++)
      begin
        wreg(OFF_SENSE_CFG, {3'b0, c[1:0], i[0], 2'b0});
        irq_step(1'b1, c[1:0], i[0]);
        irq_step(1'b0, c[1:0], i[0]);
      end
    end
    $display("Test sense codes done");
    // Pending request dropped by a sense change
    wreg(OFF_SENSE_CFG, 8'h08);
    pulse_ack(2'h1);
    @(posedge clk_in);
    ext_val[0] <= 1'b1;
    cyc(5);
    check({31'h0, irq[0]}, 32'h1);
    wreg(OFF_SENSE_CFG, 8'h18);
    cyc(0);
    check({31'h0, irq[0]}, 32'h0);
    // Group B: pins ORed, own request, cleared by vector fetch
    wreg(OFF_SENSE_CFG, 8'h58);
    cyc(2);
    check({30'h0, irq}, 32'h0);
    @(posedge clk_in);
    ext_val[6] <= 1'b1;
    cyc(5);
    check({30'h0, irq}, 32'h2);
    pulse_ack(2'h2);
    cyc(1);
    check({30'h0, irq}, 32'h0);
    @(posedge clk_in);
    ext_val[4] <= 1'b1;
    cyc(5);
    check({30'h0, irq}, 32'h2);
    $display("Test interrupt groups done");
    end_sim();
  end
endmodule // tb_gpio_port_with_ext_irq

`default_nettype wire
